// ===== src/scs_regs.v
// scs_regs.v: system control and status register bank with address map.
// assumes a same-clock byte bus with one-cycle rd/wr strobes, never both
// at once; pin inputs are asynchronous and pass the synchroniser.
//
// What this block does
// - each map entry serves one fixed 1024-byte multibus page
// - upper ten address bits pick an entry; translate only if bit 23 set
// - indicator latch is write-only, cleared at reset: power on, leds lit
// - indicator bits 0 to 2 drive leds active low
// - indicator bit 7 set commands mains power shutdown
// - switch/slot port is read-only; writes do nothing
// - bits 0 to 3 give rotary position active low
// - bits 4 to 7 give the four slot identification lines
// - remote break resets board except position 1; deadman only in 2
// - aux register read/write, reads may differ, cleared at reset
// - tape lines read on bits 0,3,4,6,7; bits 3,4,6 drive tape
// - writing 1 to aux bit 0 pulses nubus reset one bus cycle
// - aux bit 1 holds nubus reset until cleared; reads stored bit
// - aux bit 2 holds multibus init; reads stored bit
// - aux bit 5 reads converter done; writes to bits 5, 7 ignored
// - core register reads back writes, cleared at reset
// - core bit 0 joins internal and external multibus
// - with bit 0 clear, segments isolated, clocks kept, accesses time out
// - core bit 1 enables conversion; else nubus accesses time out
// - core bit 2 enables nubus time-out generation
// - core bits 4:3 choose nubus clock, 00 is the 10 MHz default
// - core bits 6:5 choose supply margin state
// - core bit 7 drives integrity contents statically onto nubus
`timescale 1ns/1ps
`include "scs_defs.vh"
module scs_regs (
    input wire clk,
    input wire rst,
    input wire [19:0] bus_addr,
    input wire bus_wr,
    input wire bus_rd,
    input wire [7:0] bus_wdata,
    output reg [7:0] bus_rdata_q,
    output reg bus_ack_q,
    input wire [3:0] rotary_position_line_n,
    input wire [3:0] slot_id,
    input wire tape_ready_n,
    input wire tape_exception_n,
    input wire adc_done,
    input wire remote_break,
    input wire xlat_req,
    input wire [19:0] xlat_addr,
    output reg [31:0] nb_addr_q,
    output reg nb_start_q,
    output reg nb_refused_q,
    input wire ext_req,
    output reg ext_pass_q,
    output reg ext_timeout_q,
    output reg [2:0] front_led_n_q,
    output reg ac_shutdown_q,
    output reg board_reset_q,
    output reg deadman_en_q,
    output reg nubus_reset_n_q,
    output reg multibus_init_n_q,
    output reg tape_reset_n_q,
    output reg tape_request_n_q,
    output reg tape_online_n_q,
    output reg mb_bridge_en_q,
    output reg bus_clock_drive_q,
    output reg nb_conv_en_q,
    output reg nb_timeout_en_q,
    output reg bus_clock_select_hi_q,
    output reg bus_clock_select_lo_q,
    output reg supply_margin_select_hi_q,
    output reg supply_margin_select_lo_q,
    output reg integrity_drive_en_q
);
    localparam [31:0] PULSE_CYCLES = `SCS_NB_CYCLES;
    localparam [31:0] PULSE_LAST_W = PULSE_CYCLES - 32'h00000001;
    localparam [4:0] PULSE_LAST = PULSE_LAST_W[4:0];

    // exact byte address match on the byte bus
    function hit;
        input [19:0] a;
        input [19:0] reg_addr;
        begin
            hit = (a == reg_addr);
        end
    endfunction

    function in_map;
        input [19:0] a;
        begin
            in_map = (a[19:12] == `SCS_MAP_HI);
        end
    endfunction

    wire [11:0] pin_s;
    wire [3:0] rot_s;
    wire [3:0] slot_s;
    wire ready_n_s;
    wire except_n_s;
    wire adc_s;
    wire break_s;

    // pin images read as zero until two edges after reset
    scs_sync #(
        .W(12)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .d({remote_break, adc_done, tape_exception_n, tape_ready_n,
            slot_id, rotary_position_line_n}),
        .q(pin_s)
    );

    assign rot_s = pin_s[3:0];
    assign slot_s = pin_s[7:4];
    assign ready_n_s = pin_s[8];
    assign except_n_s = pin_s[9];
    assign adc_s = pin_s[10];
    assign break_s = pin_s[11];

    // address map storage: three implemented bytes per entry, no reset
    // entries are undefined after power-up; software must fill the map
    // before enabling conversion, or stray valid bits start nubus cycles
    reg [7:0] map_b0 [0:1023];
    reg [7:0] map_b1 [0:1023];
    reg [7:0] map_b2 [0:1023];

    wire [9:0] bus_idx;
    wire [9:0] x_idx;
    assign bus_idx = bus_addr[11:2];
    assign x_idx = xlat_addr[19:10];

    reg [7:0] ind_q;
    reg [7:0] aux_q;
    reg [7:0] core_q;
    reg [4:0] pulse_cnt_q;
    reg pulse_q;

    wire sel_ind;
    wire sel_sw;
    wire sel_aux;
    wire sel_core;
    wire sel_map;
    wire [1:0] lane;
    wire wr_ind;
    wire wr_aux;
    wire wr_core;
    wire wr_map;
    wire mapped;

    // one decode per register, shared by the write and read paths
    assign sel_ind = hit(bus_addr, `SCS_A_IND);
    assign sel_sw = hit(bus_addr, `SCS_A_SW);
    assign sel_aux = hit(bus_addr, `SCS_A_AUX);
    assign sel_core = hit(bus_addr, `SCS_A_CORE);
    assign sel_map = in_map(bus_addr);
    assign lane = bus_addr[1:0];

    assign wr_ind = bus_wr && sel_ind;
    assign wr_aux = bus_wr && sel_aux;
    assign wr_core = bus_wr && sel_core;
    assign wr_map = bus_wr && sel_map;
    assign mapped = sel_ind || sel_sw || sel_aux || sel_core || sel_map;

    // map byte writes; byte 3 of each entry is not implemented
    always @(posedge clk) begin
        if (wr_map && lane == 2'd0) begin
            map_b0[bus_idx] <= bus_wdata;
        end
        if (wr_map && lane == 2'd1) begin
            map_b1[bus_idx] <= bus_wdata;
        end
        if (wr_map && lane == 2'd2) begin
            map_b2[bus_idx] <= bus_wdata;
        end
    end

    // register writes
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ind_q <= `SCS_IND_RST;
            aux_q <= `SCS_AUX_RST;
            core_q <= `SCS_CORE_RST;
        end else begin
            if (wr_ind) begin
                ind_q <= bus_wdata;
            end
            if (wr_aux) begin
                // bits 5 and 7 are not stored
                aux_q <= bus_wdata & 8'h5F;
            end
            if (wr_core) begin
                core_q <= bus_wdata;
            end
        end
    end

    // one-nubus-cycle reset pulse from a write of 1 to aux bit 0
    // a repeated write of bit 0 restarts the count
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pulse_q <= 1'b0;
            pulse_cnt_q <= 5'h00;
        end else if (wr_aux && bus_wdata[`SCS_AUX_RSTPULSE]) begin
            pulse_q <= 1'b1;
            pulse_cnt_q <= 5'h00;
        end else if (pulse_q) begin
            if (pulse_cnt_q == PULSE_LAST) begin
                pulse_q <= 1'b0;
            end
            pulse_cnt_q <= pulse_cnt_q + 5'h01;
        end
    end

    // read data mux; switch/slot port stores nothing on writes, which are still acked
    reg [7:0] rd_d;
    always @* begin
        rd_d = 8'h00;
        if (sel_sw) begin
            rd_d = {slot_s, rot_s};
        end else if (sel_aux) begin
            // bits 3, 4 and 6 read back the driven tape lines
            rd_d[`SCS_AUX_RSTPULSE] = ~ready_n_s;
            rd_d[`SCS_AUX_RSTHOLD] = aux_q[`SCS_AUX_RSTHOLD];
            rd_d[`SCS_AUX_INIT] = aux_q[`SCS_AUX_INIT];
            rd_d[`SCS_AUX_TRESET] = ~tape_reset_n_q;
            rd_d[`SCS_AUX_TREQ] = ~tape_request_n_q;
            rd_d[`SCS_AUX_ADCDONE] = adc_s;
            rd_d[`SCS_AUX_ONLINE] = ~tape_online_n_q;
            rd_d[`SCS_AUX_EXCEPT] = ~except_n_s;
        end else if (sel_core) begin
            rd_d = core_q;
        end else if (sel_map) begin
            case (lane)
                2'd0: begin
                    rd_d = map_b0[bus_idx];
                end
                2'd1: begin
                    rd_d = map_b1[bus_idx];
                end
                2'd2: begin
                    rd_d = map_b2[bus_idx];
                end
                default: begin
                    rd_d = 8'h00;
                end
            endcase
        end
        // indicator latch is write-only and reads as zero
    end

    // bus answer one cycle after the strobe, only for decoded addresses
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_rdata_q <= 8'h00;
            bus_ack_q <= 1'b0;
        end else begin
            bus_ack_q <= (bus_wr || bus_rd) && mapped;
            if (bus_rd && mapped) begin
                bus_rdata_q <= rd_d;
            end
        end
    end

    // multibus to nubus translation through the map
    // an invalid entry is not a nubus access and gets no answer here
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            nb_addr_q <= 32'h00000000;
            nb_start_q <= 1'b0;
            nb_refused_q <= 1'b0;
        end else begin
            nb_start_q <= 1'b0;
            nb_refused_q <= 1'b0;
            if (xlat_req && map_b2[x_idx][`SCS_MAP_VALID]) begin
                if (core_q[`SCS_CORE_CONVEN]) begin
                    // entry bits 21:0 over the page offset
                    nb_addr_q <= {map_b2[x_idx][5:0], map_b1[x_idx],
                                  map_b0[x_idx], xlat_addr[9:0]};
                    nb_start_q <= 1'b1;
                end else begin
                    nb_refused_q <= 1'b1;
                end
            end
        end
    end

    // external multibus access through the bridge
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_pass_q <= 1'b0;
            ext_timeout_q <= 1'b0;
        end else begin
            ext_pass_q <= ext_req && core_q[`SCS_CORE_MBEN];
            ext_timeout_q <= ext_req && !core_q[`SCS_CORE_MBEN];
        end
    end

    // pin-facing outputs, each from its own flop
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            front_led_n_q <= 3'h0;
            ac_shutdown_q <= 1'b0;
            board_reset_q <= 1'b0;
            deadman_en_q <= 1'b0;
            nubus_reset_n_q <= 1'b1;
            multibus_init_n_q <= 1'b1;
            tape_reset_n_q <= 1'b1;
            tape_request_n_q <= 1'b1;
            tape_online_n_q <= 1'b1;
            mb_bridge_en_q <= 1'b0;
            bus_clock_drive_q <= 1'b0;
            nb_conv_en_q <= 1'b0;
            nb_timeout_en_q <= 1'b0;
            bus_clock_select_hi_q <= 1'b0;
            bus_clock_select_lo_q <= 1'b0;
            supply_margin_select_hi_q <= 1'b0;
            supply_margin_select_lo_q <= 1'b0;
            integrity_drive_en_q <= 1'b0;
        end else begin
            front_led_n_q <= ind_q[`SCS_IND_LED_HI:`SCS_IND_LED_LO];
            ac_shutdown_q <= ind_q[`SCS_IND_ACOFF];
            board_reset_q <= break_s && (rot_s != `SCS_POS1);
            deadman_en_q <= (rot_s == `SCS_POS2);
            nubus_reset_n_q <= ~(pulse_q ||
                                 aux_q[`SCS_AUX_RSTHOLD]);
            multibus_init_n_q <= ~aux_q[`SCS_AUX_INIT];
            tape_reset_n_q <= ~aux_q[`SCS_AUX_TRESET];
            tape_request_n_q <= ~aux_q[`SCS_AUX_TREQ];
            tape_online_n_q <= ~aux_q[`SCS_AUX_ONLINE];
            mb_bridge_en_q <= core_q[`SCS_CORE_MBEN];
            // multibus clocks keep running even with the bridge off
            bus_clock_drive_q <= 1'b1;
            nb_conv_en_q <= core_q[`SCS_CORE_CONVEN];
            nb_timeout_en_q <= core_q[`SCS_CORE_TOEN];
            bus_clock_select_hi_q <= core_q[`SCS_CORE_CLK_HI];
            bus_clock_select_lo_q <= core_q[`SCS_CORE_CLK_LO];
            supply_margin_select_hi_q <= core_q[`SCS_CORE_VOLT_HI];
            supply_margin_select_lo_q <= core_q[`SCS_CORE_VOLT_LO];
            integrity_drive_en_q <= core_q[`SCS_CORE_INTEG];
        end
    end
endmodule

// ===== src/scs_defs.vh
// scs_defs.vh: addresses, bit positions, reset values and timing counts
// of the system control and status register bank.
// included by the design files of the scs block; definitions only.
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH

// byte addresses on the internal multibus
`define SCS_A_IND 20'h1C080
`define SCS_A_SW 20'h1C084
`define SCS_A_AUX 20'h1C088
`define SCS_A_CORE 20'h1C08C
// address map window 0x18000-0x18FFF, four bytes per entry
`define SCS_MAP_HI 8'h18
`define SCS_MAP_VALID 7
`define SCS_MAP_VALID_BIT 23

// indicator_power_latch fields
`define SCS_IND_LED_LO 0
`define SCS_IND_LED_HI 2
`define SCS_IND_ACOFF 7

// aux_control_status fields
`define SCS_AUX_RSTPULSE 0
`define SCS_AUX_RSTHOLD 1
`define SCS_AUX_INIT 2
`define SCS_AUX_TRESET 3
`define SCS_AUX_TREQ 4
`define SCS_AUX_ADCDONE 5
`define SCS_AUX_ONLINE 6
`define SCS_AUX_EXCEPT 7

// core_control_status fields
`define SCS_CORE_MBEN 0
`define SCS_CORE_CONVEN 1
`define SCS_CORE_TOEN 2
`define SCS_CORE_CLK_LO 3
`define SCS_CORE_CLK_HI 4
`define SCS_CORE_VOLT_LO 5
`define SCS_CORE_VOLT_HI 6
`define SCS_CORE_INTEG 7

// reset values
`define SCS_IND_RST 8'h00
`define SCS_AUX_RST 8'h00
`define SCS_CORE_RST 8'h00

// rotary switch codes, active low
`define SCS_POS0 4'hF
`define SCS_POS1 4'hE
`define SCS_POS2 4'hD

// timing: one nubus cycle at the 10 MHz default rate
`define SCS_CLK_NS 5
`define SCS_NB_CYCLE_NS 100
`define SCS_NB_CYCLES ((`SCS_NB_CYCLE_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)

`endif

// ===== src/scs_sync.v
// scs_sync.v: two-flop synchroniser, one chain per bit.
// assumes each bit is a slow level from outside the clk domain.
`timescale 1ns/1ps
module scs_sync #(
    parameter W = 14
) (
    input wire clk,
    input wire rst,
    input wire [W-1:0] d,
    output wire [W-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg s1_q;
            reg s2_q;
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                end else begin
                    s1_q <= d[i];
                    s2_q <= s1_q;
                end
            end
            assign q[i] = s2_q;
        end
    endgenerate
endmodule

// ===== bench/scs_properties.sv
// scs_properties.sv: timing checks on the register bank ports.
// assumes it is bound to scs_regs; one clock, rst async active high.
`timescale 1ns/1ps
`include "scs_defs.vh"
module scs_properties (
    input logic clk,
    input logic rst,
    input logic [19:0] bus_addr,
    input logic bus_wr,
    input logic bus_rd,
    input logic [7:0] bus_wdata,
    input logic [7:0] bus_rdata_q,
    input logic bus_ack_q,
    input logic [3:0] rotary_position_line_n,
    input logic remote_break,
    input logic ext_req,
    input logic ext_pass_q,
    input logic ext_timeout_q,
    input logic [2:0] front_led_n_q,
    input logic ac_shutdown_q,
    input logic board_reset_q,
    input logic deadman_en_q,
    input logic nubus_reset_n_q,
    input logic multibus_init_n_q,
    input logic tape_reset_n_q,
    input logic tape_request_n_q,
    input logic tape_online_n_q,
    input logic mb_bridge_en_q,
    input logic nb_conv_en_q,
    input logic nb_timeout_en_q,
    input logic bus_clock_select_hi_q,
    input logic bus_clock_select_lo_q,
    input logic supply_margin_select_hi_q,
    input logic supply_margin_select_lo_q,
    input logic integrity_drive_en_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire [7:0] core_q = {integrity_drive_en_q, supply_margin_select_hi_q,
        supply_margin_select_lo_q, bus_clock_select_hi_q,
        bus_clock_select_lo_q, nb_timeout_en_q, nb_conv_en_q,
        mb_bridge_en_q};
    wire wr_aux = bus_wr && bus_addr == `SCS_A_AUX;
    reg [2:0] up_q;
    // pin outputs trail the synchroniser, so wait after reset
    always @(posedge clk or posedge rst) begin
        if (rst)
            up_q <= 3'h0;
        else if (up_q != 3'h7)
            up_q <= up_q + 3'h1;
    end
    a_mapped_ack: assert property (
        bus_wr && bus_addr == `SCS_A_CORE ||
        bus_rd && bus_addr == `SCS_A_SW |=> bus_ack_q) else $error("no ack");
    a_unmapped_silent: assert property ((bus_wr || bus_rd) &&
        bus_addr == 20'h1C090 |=> !bus_ack_q) else $error("unmapped ack");
    a_core_drive: assert property (bus_wr && bus_addr == `SCS_A_CORE
        |-> ##2 core_q == $past(bus_wdata, 2)) else $error("core outputs");
    a_core_read: assert property (bus_rd && bus_addr == `SCS_A_CORE
        |=> bus_rdata_q == core_q) else $error("core read data");
    a_ind_drive: assert property (bus_wr &&
        bus_addr == `SCS_A_IND |-> ##2
        {ac_shutdown_q, 4'h0, front_led_n_q} ==
        ($past(bus_wdata, 2) & 8'h87)) else $error("indicator outputs");
    a_aux_drive: assert property (wr_aux |-> ##2
        (~$past(bus_wdata, 2) & 8'h5C) == {1'b0, tape_online_n_q, 1'b0,
        tape_request_n_q, tape_reset_n_q, multibus_init_n_q, 2'h0})
        else $error("aux outputs");
    a_hold_reset: assert property (wr_aux && bus_wdata[1] |-> ##2
        !nubus_reset_n_q) else $error("bus reset not held");
    a_pulse_len: assert property (wr_aux && bus_wdata == 8'h01 |->
        ##2 !nubus_reset_n_q ##19 !nubus_reset_n_q ##1 nubus_reset_n_q)
        else $error("bus reset pulse length");
    a_ext_route: assert property (ext_req |=> ext_pass_q ==
        mb_bridge_en_q && ext_timeout_q != mb_bridge_en_q)
        else $error("external access routing");
    a_switch_opts: assert property (up_q == 3'h7 && remote_break ==
        $past(remote_break, 4) && rotary_position_line_n ==
        $past(rotary_position_line_n, 4) |-> deadman_en_q ==
        (rotary_position_line_n == `SCS_POS2) && board_reset_q ==
        (remote_break && rotary_position_line_n != `SCS_POS1))
        else $error("switch options");
endmodule

// ===== bench/scs_pins_model.sv
// scs_pins_model.sv: rotary switch, slot lines and tape status pins.
// assumes the bench picks position, slot and tape line states.
`timescale 1ns/1ps
module scs_pins_model (
    input logic [2:0] pos,
    input logic [3:0] slot,
    input logic ready,
    input logic exc,
    output logic [3:0] rotary_position_line_n,
    output logic [3:0] slot_id,
    output logic tape_ready_n,
    output logic tape_exception_n
);
    // positions 0 and 5 to 7 leave all lines high, positions 1 to 4 pull one line low
    assign rotary_position_line_n = (pos == 3'h0) ? 4'hF :
        ~(4'h1 << (pos - 3'h1));
    assign slot_id = slot;
    assign tape_ready_n = ~ready;
    assign tape_exception_n = ~exc;
endmodule

// ===== bench/scs_regs_tb.sv
// scs_regs_tb.sv: self-checking bench for the register bank.
// assumes scs_regs, the pin model and the checker are compiled before.
`timescale 1ns/1ps
`include "scs_defs.vh"
module scs_regs_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [19:0] bus_addr = 20'h00000;
    logic [19:0] xlat_addr = 20'h00000;
    logic bus_wr = 1'b0, bus_rd = 1'b0, xlat_req = 1'b0, ext_req = 1'b0;
    logic ready = 1'b1, exc = 1'b0, adc_done = 1'b1, remote_break = 1'b0;
    logic [7:0] bus_wdata = 8'h00;
    logic [2:0] pos = 3'h0;
    logic [3:0] slot = 4'h0;
    logic [7:0] bus_rdata_q, rv;
    logic [3:0] rotary_position_line_n, slot_id;
    logic [31:0] nb_addr_q;
    logic [2:0] front_led_n_q;
    logic bus_ack_q, tape_ready_n, tape_exception_n, nb_start_q;
    logic nb_refused_q, ext_pass_q, ext_timeout_q, ac_shutdown_q;
    logic board_reset_q, deadman_en_q, nubus_reset_n_q, multibus_init_n_q;
    logic tape_reset_n_q, tape_request_n_q, tape_online_n_q;
    logic mb_bridge_en_q, bus_clock_drive_q, nb_conv_en_q, nb_timeout_en_q;
    logic bus_clock_select_hi_q, bus_clock_select_lo_q;
    logic supply_margin_select_hi_q, supply_margin_select_lo_q;
    logic integrity_drive_en_q;
    // margin codes return to normal only via 11, hold shortened
    logic [7:0] cv [8] = '{8'h01, 8'h0A, 8'h12, 8'h1C, 8'h20, 8'h40,
        8'h60, 8'h81};
    logic [3:0] rot [5] = '{4'hF, 4'hE, 4'hD, 4'hB, 4'h7};
    int n_mismatch = 0, tests_run = 0, cyc = 0, n;
    wire [7:0] core_q = {integrity_drive_en_q, supply_margin_select_hi_q,
        supply_margin_select_lo_q, bus_clock_select_hi_q,
        bus_clock_select_lo_q, nb_timeout_en_q, nb_conv_en_q,
        mb_bridge_en_q};
    wire [4:0] lines_n = {nubus_reset_n_q, multibus_init_n_q,
        tape_reset_n_q, tape_request_n_q, tape_online_n_q};

    scs_regs i_dut (.*);
    scs_pins_model i_pins (.*);

    always #2.5 clk = ~clk;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task acc(input logic w, input logic [19:0] a, input logic [7:0] d,
        input logic ack);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= w;
        bus_rd <= ~w;
        @(posedge clk);
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        #1;
        rv = bus_rdata_q;
        chk({31'h0, bus_ack_q}, {31'h0, ack});
    endtask

    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task pulse_in(input logic ext, input logic [19:0] a);
        @(posedge clk);
        xlat_addr <= a;
        xlat_req <= ~ext;
        ext_req <= ext;
        @(posedge clk);
        xlat_req <= 1'b0;
        ext_req <= 1'b0;
        #1;
    endtask

    task print_verdict;
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict;
        end
    end

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        settle;
        chk({front_led_n_q, ac_shutdown_q}, 4'h0);
        chk(bus_clock_drive_q, 1'b1);
        acc(1'b0, `SCS_A_CORE, 8'h00, 1'b1);
        chk(rv, 8'h00);
        acc(1'b0, `SCS_A_AUX, 8'h00, 1'b1);
        chk(rv, 8'h21);
        foreach (cv[i]) begin
            acc(1'b1, `SCS_A_CORE, cv[i], 1'b1);
            settle;
            chk(core_q, cv[i]);
            acc(1'b0, `SCS_A_CORE, 8'h00, 1'b1);
            chk(rv, cv[i]);
            pulse_in(1'b1, 20'h00000);
            chk({ext_pass_q, ext_timeout_q}, {cv[i][0], ~cv[i][0]});
        end
        acc(1'b1, `SCS_A_IND, 8'h85, 1'b1);
        settle;
        chk({ac_shutdown_q, front_led_n_q}, 4'hD);
        acc(1'b0, `SCS_A_IND, 8'h00, 1'b1);
        acc(1'b1, `SCS_A_IND, 8'h00, 1'b1);
        for (int p = 0; p < 5; p++) begin
            @(posedge clk);
            pos <= p[2:0];
            slot <= 4'h6 + p[3:0];
            remote_break <= 1'b1;
            repeat (6) @(posedge clk);
            #1;
            chk({deadman_en_q, board_reset_q}, {p == 2, p != 1});
            acc(1'b1, `SCS_A_SW, 8'h00, 1'b1);
            acc(1'b0, `SCS_A_SW, 8'h00, 1'b1);
            chk(rv, {4'h6 + p[3:0], rot[p]});
        end
        @(posedge clk);
        remote_break <= 1'b0;
        ready <= 1'b0;
        exc <= 1'b1;
        adc_done <= 1'b0;
        acc(1'b1, `SCS_A_AUX, 8'hFE, 1'b1);
        settle;
        chk(lines_n, 5'h00);
        acc(1'b0, `SCS_A_AUX, 8'h00, 1'b1);
        chk(rv, 8'hDE);
        acc(1'b1, `SCS_A_AUX, 8'h00, 1'b1);
        settle;
        chk(lines_n, 5'h1F);
        acc(1'b1, `SCS_A_AUX, 8'h01, 1'b1);
        n = 0;
        repeat (30) begin
            @(posedge clk);
            #1;
            n += !nubus_reset_n_q;
        end
        chk(n, 20);
        acc(1'b1, 20'h184C8, 8'h34, 1'b1);
        acc(1'b1, 20'h184C9, 8'h12, 1'b1);
        acc(1'b1, 20'h184CA, 8'h80, 1'b1);
        acc(1'b1, `SCS_A_CORE, 8'h02, 1'b1);
        settle;
        pulse_in(1'b0, 20'h4C855);
        chk({nb_start_q, nb_refused_q}, 2'h2);
        chk(nb_addr_q, {22'h001234, 10'h055});
        acc(1'b1, `SCS_A_CORE, 8'h00, 1'b1);
        settle;
        pulse_in(1'b0, 20'h4C855);
        chk({nb_start_q, nb_refused_q}, 2'h1);
        acc(1'b1, 20'h184CA, 8'h7F, 1'b1);
        acc(1'b1, `SCS_A_CORE, 8'h02, 1'b1);
        settle;
        pulse_in(1'b0, 20'h4C9FF);
        chk({nb_start_q, nb_refused_q}, 2'h0);
        acc(1'b0, 20'h1C090, 8'h00, 1'b0);
        acc(1'b1, 20'h1C090, 8'h55, 1'b0);
        print_verdict;
    end
endmodule

bind scs_regs scs_properties i_props (.*);
